/* File: dv/rrxage_far_model.sv */
// Demodulator-side model: sync, byte stream, CRC verdict, readings.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/10ps
module rrxage_far_model
(
  input  wire logic  clock,          // System clock
  output logic       sync_found,     // Sync pulse
  output logic       byte_valid,     // Byte strobe
  output logic [7:0] rx_byte,        // Byte value
  output logic       pkt_end,        // End of packet pulse
  output logic       crc_ok,         // CRC verdict
  output logic       strength_valid, // Reading strobe
  output logic [7:0] strength        // Reading value
);
  // Idle cycles between bytes, at least one so strobes never merge
  int gap = 1;
  // Quiet lines at time zero
  initial
  begin
    {sync_found, byte_valid, pkt_end, crc_ok, strength_valid} = 5'h00;
    rx_byte = 8'h00;
    strength = 8'h00;
  end
  // Reading ahead of sync gives the gain loop its lead-in
  task automatic reading(input logic [7:0] v);
    strength_valid <= 1'b1;
    strength <= v;
    @(posedge clock);
    strength_valid <= 1'b0;
    strength <= ~v; // Stale value is never left standing
    @(posedge clock);
  endtask
  task automatic sync_only();
    sync_found <= 1'b1;
    @(posedge clock);
    sync_found <= 1'b0;
  endtask
  // Bytes go out first byte from the top of b
  task automatic body(input logic [23:0] b, input int n, input logic ok);
    for (int i = 0; i < n; i++)
    begin
      byte_valid <= 1'b1;
      rx_byte <= b[23-8*i -: 8];
      @(posedge clock);
      byte_valid <= 1'b0;
      rx_byte <= ~b[23-8*i -: 8];
      repeat (gap) @(posedge clock);
    end
    pkt_end <= 1'b1;
    crc_ok <= ok;
    @(posedge clock);
    pkt_end <= 1'b0;
    crc_ok <= ~ok;
  endtask
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the receive task and gain engine.
// Assumes a zero-wait register bus and the far-side model.
`timescale 1ns/10ps
module tb
  import rrxage_pkg::*;
;
  typedef struct packed {
    logic [9:0]  ctl; // Control word
    logic [23:0] b;   // Bytes after sync
    logic [1:0]  n;   // Byte count
    logic        ok;  // CRC verdict
    logic [2:0]  k;   // 0 drop, 1 good, 2 empty, 3 bad, 4 overflow
    logic [2:0]  ent; // Entry used
    logic        dc;  // Flush expected
  } rrxage_row_t;
  logic clock, srst, hwrite, hsel, rx_cmd, stop_event, fifo_full, mod_underflow;
  logic hreadyout, hresp, sync_found, byte_valid, pkt_end, crc_ok, strength_valid;
  logic capture_pulse, discard_rx_fifo, tone_enable, task_done;
  logic rx_good_irq, rx_empty_irq, rx_bad_irq, rx_overflow_irq;
  logic [31:0] haddr, hwdata, hrdata, rd, cb;
  logic [15:0] tone_length, synth_reduction;
  logic [7:0]  rx_byte, strength, gain, stat;
  logic [6:0]  channel_number, ev, exp;
  logic [2:0]  hsize;
  logic [1:0]  htrans;
  int          fails = 0, check_count = 0, t, cnt[7] = '{default: 0}, c0[7];
  time         t0;
  rrxage_row_t r;
  logic [7:0]  lv[4] = '{8'h40, 8'h20, 8'h05, 8'h40};
  logic [7:0]  le[4] = '{8'h03, 8'h03, 8'h0c, 8'h03};
  rrxage_row_t rows[12] = '{
    '{10'h38c, 24'h035a11, 2'd3, 1'b1, 3'd1, 3'd0, 1'b0},
    '{10'h38c, 24'h015a00, 2'd2, 1'b1, 3'd2, 3'd0, 1'b1},
    '{10'h38c, 24'h035a11, 2'd3, 1'b0, 3'd3, 3'd0, 1'b1},
    '{10'h388, 24'h5a1122, 2'd3, 1'b1, 3'd1, 3'd0, 1'b0},
    '{10'h388, 24'h330000, 2'd1, 1'b1, 3'd2, 3'd1, 1'b1},
    '{10'h380, 24'h112200, 2'd2, 1'b1, 3'd1, 3'd0, 1'b0},
    '{10'h20c, 24'h035a11, 2'd3, 1'b0, 3'd3, 3'd0, 1'b0},
    '{10'h20c, 24'h015a00, 2'd2, 1'b1, 3'd2, 3'd0, 1'b0},
    '{10'h38c, 24'h035a11, 2'd3, 1'b1, 3'd4, 3'd0, 1'b1},
    '{10'h38c, 24'h005a00, 2'd2, 1'b1, 3'd0, 3'd0, 1'b0},
    '{10'h38c, 24'h055a11, 2'd3, 1'b1, 3'd0, 3'd0, 1'b0},
    '{10'h38c, 24'h037711, 2'd3, 1'b1, 3'd0, 3'd0, 1'b0}};

  rrxage_top DUT (.clock, .srst, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hsel,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_cmd, .stop_event, .sync_found,
    .byte_valid, .rx_byte, .pkt_end, .crc_ok, .fifo_full, .strength_valid, .strength,
    .mod_underflow, .front_end_gain_setting(gain), .capture_pulse, .discard_rx_fifo,
    .tone_enable, .tone_length, .synth_reduction, .channel_number, .rx_good_irq,
    .rx_empty_irq, .rx_bad_irq, .rx_overflow_irq, .task_done, .status_result_byte(stat));
  rrxage_far_model u_far (.clock, .sync_found, .byte_valid, .rx_byte, .pkt_end,
    .crc_ok, .strength_valid, .strength);

  // 250 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Pulses counted at the falling edge, once they have settled
  always @(negedge clock)
  begin
    ev = {task_done, capture_pulse, discard_rx_fifo, rx_overflow_irq,
          rx_bad_irq, rx_empty_irq, rx_good_irq};
    for (int i = 0; i < 7; i++)
      if (ev[i] === 1'b1) cnt[i]++;
  end

  task automatic chk(input logic c, input string m);
    check_count++;
    if (c !== 1'b1)
    begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic end_of_test();
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Bounded wait for the slave to take a bus phase
  task automatic hold();
    int k;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) chk(1'b0, "bus hang");
    if (k >= 50) end_of_test();
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hold();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    hold();
    rd = hrdata;
  endtask
  task automatic start();
    c0 = cnt;
    rx_cmd <= 1'b1;
    @(posedge clock);
    rx_cmd <= 1'b0;
    t0 = $time;
  endtask
  task automatic wait_done(input int lim);
    int k;
    k = 0;
    while (cnt[6] == c0[6] && k < lim)
    begin
      @(posedge clock);
      k++;
    end
    if (k >= lim) chk(1'b0, "no task end");
    if (k >= lim) end_of_test();
    t = int'(($time - t0) / 4);
  endtask

  // Main sequence: table of packets, then the awkward cases
  initial
  begin
    {srst, hsel, hwrite, rx_cmd, stop_event, fifo_full, mod_underflow} = 7'h40;
    {htrans, haddr, hwdata, hsize} = {2'b00, 32'h0, 32'h0, 3'b010};
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(rd === RESET_ZERO, "control reset");
    bus(1'b1, 8'hfc, 32'hffff_ffff);
    bus(1'b0, 8'hfc, 32'h0);
    chk(rd === 32'h0 && hresp === 1'b0, "unmapped word");
    bus(1'b1, OFS_ENTRY0, 32'h0003_015a); // entries set while idle
    bus(1'b1, OFS_ENTRY0 + 8'h04, 32'h0001_0133);
    bus(1'b1, OFS_SEARCH, 32'd120);
    foreach (rows[i])
    begin
      r = rows[i];
      bus(1'b1, OFS_CTRL, {22'h0, r.ctl});
      bus(1'b0, OFS_COUNT0 + {3'h0, r.ent, 2'h0}, 32'h0);
      cb = rd;
      fifo_full <= (r.k == 3'd4);
      u_far.gap = i % 2 + 1;
      start();
      u_far.sync_only();
      u_far.body(r.b, int'(r.n), r.ok);
      wait_done(300);
      fifo_full <= 1'b0;
      exp = {2'b11, r.dc, 4'h0} | (r.k != 3'd0 ? 7'h01 << (r.k - 3'd1) : 7'h00);
      for (int j = 0; j < 7; j++)
        chk(cnt[j] - c0[j] == int'(exp[j]), "event count");
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(rd[7:0] === (r.k == 3'd0 ? end_no_sync : END_OK), "end cause");
      if (r.k == 3'd0) chk(t >= 116 && t <= 126, "search time");
      if (r.k != 3'd0 && r.ctl[9])
        chk(rd[15] === r.ok && stat[7] === r.ok, "crc result bit");
      bus(1'b0, OFS_COUNT0 + {3'h0, r.ent, 2'h0}, 32'h0);
      chk(rd === cb + (r.k == 3'd3 ? 32'h1_0000 : {31'h0, (r.k inside {3'd1, 3'd2})}),
          "counter");
      repeat (2) @(posedge clock);
    end
    // Gain loop: hysteresis, freeze at sync, restore at end
    bus(1'b1, OFS_GAIN, 32'h000c_1503);
    bus(1'b1, OFS_LIMITS, 32'h0006_3010);
    bus(1'b1, OFS_CTRL, 32'h0000_038d);
    @(posedge clock);
    chk(channel_number === 7'h15, "channel");
    start();
    repeat (2) @(posedge clock);
    chk(gain === 8'h0c, "start gain");
    for (int j = 0; j < 4; j++)
    begin
      u_far.reading(lv[j]);
      @(posedge clock);
      chk(gain === le[j], "gain step");
    end
    u_far.sync_only();
    u_far.reading(8'h05);
    @(posedge clock);
    chk(gain === 8'h03, "gain frozen");
    u_far.body(24'h035a11, 3, 1'b1);
    wait_done(300);
    repeat (3) @(posedge clock);
    chk(gain === 8'h0c, "gain restored");
    bus(1'b0, OFS_STRENGTH, 32'h0);
    chk(rd[7:0] === 8'h0b, "reported strength");
    // Start tone: nine preamble bytes at the fast rate, offset too big
    bus(1'b1, OFS_TONE, 32'h2000_04ca);
    bus(1'b1, OFS_CTRL, 32'h2);
    @(posedge clock);
    chk(tone_enable === 1'b1 && tone_length === 16'h04ca, "tone");
    chk(synth_reduction === TONE_OFS_MAX, "offset cap");
    bus(1'b1, OFS_TONE, 32'h0600_00ca);
    @(posedge clock);
    chk(synth_reduction === 16'h0600, "offset");
    start();
    mod_underflow <= 1'b1;
    @(posedge clock);
    mod_underflow <= 1'b0;
    wait_done(100);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd[7:0] === end_modulator_underflow, "underflow cause");
    // Timer event governs the search, the short limit must not end it
    bus(1'b1, OFS_SEARCH, 32'd30);
    for (int s = 0; s < 2; s++)
    begin
      bus(1'b1, OFS_CTRL, 32'h60 | (32'(s) << 4));
      start();
      repeat (60) @(posedge clock);
      chk(cnt[6] == c0[6], "limit ignored");
      stop_event <= 1'b1;
      @(posedge clock);
      stop_event <= 1'b0;
      wait_done(50);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(rd[7:0] === END_RX_TIMEOUT, "event end");
    end
    // Reset in mid-task clears everything
    start();
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(rd === RESET_ZERO && gain === 8'h00, "mid-run reset");
    end_of_test();
  end
endmodule

/* File: logic/rrxage_agc.sv */
// Two-level gain control with hysteresis, held after sync.
// Assumes strength_valid pulses once per averaged reading.
`timescale 1ns/10ps
module rrxage_agc
  import rrxage_pkg::*;
#(
  parameter int GW = 8
)(
  input  wire logic          clock,           // System clock
  input  wire logic          srst,            // Sync reset
  input  wire logic          enable,          // Gain control on
  input  wire logic          task_start,      // Task start pulse
  input  wire logic          rx_off,          // Receiver off pulse
  input  wire logic          sync_hold,       // Sync obtained, freeze
  input  wire logic          strength_valid,  // New reading
  input  wire logic [7:0]    strength,        // Signed reading
  input  wire logic [7:0]    lower_limit,     // Lower threshold
  input  wire logic [7:0]    upper_limit,     // Upper threshold
  input  wire logic [GW-1:0] gain_in,         // Gain at task start
  input  wire logic [GW-1:0] sat_gain,        // Low gain value
  output logic      [GW-1:0] gain_out,        // Front-end gain
  output logic               gain_low         // Low gain in use
);
  logic [GW-1:0] high_ff;
  logic [GW-1:0] gain_ff;
  logic [GW-1:0] nxt_gain;
  logic          low_ff;
  logic          nxt_low;
  wire below = $signed(strength) < $signed(lower_limit);
  wire above = $signed(strength) > $signed(upper_limit);
  wire upd   = enable && strength_valid && !sync_hold;
  // Gain choice per reading; between limits keeps value
  assign nxt_low  = task_start ? 1'b0 : rx_off ? 1'b0 :
                    (upd && below) ? 1'b0 : (upd && above) ? 1'b1 : low_ff;
  assign nxt_gain = task_start ? gain_in : rx_off ? high_ff :
                    nxt_low ? sat_gain : high_ff;
  // High gain captured when task starts
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      high_ff <= '0;
      gain_ff <= '0;
      low_ff  <= 1'b0;
    end
    else
    begin
      if (task_start)
        high_ff <= gain_in;
      gain_ff <= nxt_gain;
      low_ff  <= nxt_low;
    end
  end
  assign gain_out = gain_ff;
  assign gain_low = low_ff;
  chk_agc_low_on_high: assert property (@(posedge clock) disable iff (srst)
    (upd && above && !task_start && !rx_off) |=> (gain_low && gain_out == $past(sat_gain)))
    else $error("gain not lowered above limit");
  chk_agc_hold_sync: assert property (@(posedge clock) disable iff (srst)
    (sync_hold && !task_start && !rx_off) |=> $stable(gain_low))
    else $error("gain changed after sync");
  chk_agc_restore: assert property (@(posedge clock) disable iff (srst)
    (rx_off && !task_start) |=> (gain_out == high_ff && !gain_low))
    else $error("gain not restored on receiver off");
endmodule

/* File: logic/rrxage_pkg.sv */
// Package for the radio receive-task and gain-control engine.
// Assumes AHB-Lite register access with 32-bit aligned words.
package rrxage_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_GAIN      = 8'h04;
  localparam logic [7:0] OFS_LIMITS    = 8'h08;
  localparam logic [7:0] OFS_TONE      = 8'h0c;
  localparam logic [7:0] OFS_SEARCH    = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;
  localparam logic [7:0] OFS_STRENGTH  = 8'h18;
  localparam logic [7:0] OFS_ENTRY0    = 8'h20;
  localparam logic [7:0] OFS_COUNT0    = 8'h40;
  localparam int         ENTRIES       = 8;
  // Control field positions
  localparam int CTRL_GAIN_CONTROL_ENABLE     = 0;
  localparam int CTRL_TONE_EN    = 1;
  localparam int CTRL_MODE       = 2;
  localparam int CTRL_ADDRESS_LENGTH_SELECT   = 3;
  localparam int CTRL_START_SEL  = 4;
  localparam int CTRL_STOP_LO    = 5;
  localparam int CTRL_FLUSH_CRC  = 7;
  localparam int CTRL_FLUSH_EMP  = 8;
  localparam int CTRL_STATUS_EN  = 9;
  // End causes
  localparam logic [7:0] END_OK                  = 8'h00;
  localparam logic [7:0] END_RX_TIMEOUT          = 8'h01;
  localparam logic [7:0] end_no_sync             = 8'h02;
  localparam logic [7:0] end_modulator_underflow = 8'hf9;
  // Tone offset ceiling: 4096 system ticks, 16.384 us at 250 MHz
  localparam logic [15:0] TONE_OFS_MAX = 16'h1000;
  localparam logic [7:0]  STOP_FIRST_ONLY = 8'h03;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  typedef enum logic [2:0] {
    RRX_IDLE   = 3'b000,
    RRX_SEARCH = 3'b001,
    RRX_LEN    = 3'b011,
    RRX_ADDR   = 3'b010,
    RRX_BODY   = 3'b110,
    RRX_DONE   = 3'b111
  } rrxage_state_t;
endpackage

/* File: logic/rrxage_top.sv */
// Receive task engine: sync search, length and address filter,
// CRC result handling, flush and counters, start-tone control.
// Assumes one AHB-Lite master and a demodulator byte stream.
// How it works
// - Gain control active during search when enabled
// - Below lower high gain, above upper low
// - Gain frozen at sync, restored at off
// - Reported strength adds offset when gain lowered
// - Start tone replaces first preamble bytes
// - Tone shortens synth start, offset capped 4096
// - Tone too long ends task underflow
// - Search time limit ends task no sync
// - Stop/start selects which timeout governs search
// - Sync found pulses the timer capture
// - Length too short for address drops packet
// - Address matched against enabled entries
// - Length from entry or checked against it
// - Dropped packets keep timeouts and first status
// - CRC result in status, flush on fail
// - Empty packets flushed when enabled
// - FIFO overflow on packets not flushed raises overflow interrupt instead
// - Interrupts and per-entry counters after packet
// - No-sync end cause has value two
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module rrxage_top
  import rrxage_pkg::*;
#(
  parameter int GW = 8
)(
  input  wire logic          clock,          // 250 MHz clock
  input  wire logic          srst,           // Sync reset, high
  input  wire logic [31:0]   haddr,          // AHB address
  input  wire logic [1:0]    htrans,         // AHB transfer type
  input  wire logic          hwrite,         // AHB write
  input  wire logic [2:0]    hsize,          // AHB size
  input  wire logic [31:0]   hwdata,         // AHB write data
  input  wire logic          hsel,           // AHB select
  input  wire logic          hready,         // AHB ready in
  output logic      [31:0]   hrdata,         // AHB read data
  output logic               hreadyout,      // AHB ready out
  output logic               hresp,          // AHB response
  input  wire logic          rx_cmd,         // Receive command pulse
  input  wire logic          stop_event,     // Timer event 2 pulse
  input  wire logic          sync_found,     // Demod sync pulse
  input  wire logic          byte_valid,     // Received byte strobe
  input  wire logic [7:0]    rx_byte,        // Received byte
  input  wire logic          pkt_end,        // Last byte received
  input  wire logic          crc_ok,         // CRC check result
  input  wire logic          fifo_full,      // RX FIFO full
  input  wire logic          strength_valid, // Reading strobe
  input  wire logic [7:0]    strength,       // Hardware reading
  input  wire logic          mod_underflow,  // Modulator underflow
  output logic      [GW-1:0] front_end_gain_setting, // Gain to front end
  output logic               capture_pulse,  // Timer capture
  output logic               discard_rx_fifo,// Flush command
  output logic               tone_enable,    // Transmit start tone
  output logic      [15:0]   tone_length,    // Tone length ticks
  output logic      [15:0]   synth_reduction,// Synth startup cut
  output logic      [6:0]    channel_number, // Channel to tune
  output logic               rx_good_irq,    // Good packet pulse
  output logic               rx_empty_irq,   // Empty packet pulse
  output logic               rx_bad_irq,     // Bad packet pulse
  output logic               rx_overflow_irq,// Overflow pulse
  output logic               task_done,      // Task end pulse
  output logic      [7:0]    status_result_byte // Status byte
);
  // Software registers
  logic [31:0] ctrl_ff, gain_ff, lim_ff, tone_ff, search_ff;
  logic [31:0] entry_ff [ENTRIES];
  logic [15:0] good_ff  [ENTRIES];
  logic [15:0] bad_ff   [ENTRIES];
  logic [7:0]  cause_ff, last_str_ff, res_ff;
  // Task state
  rrxage_state_t state_ff, nxt_state;
  logic [31:0] timer_ff;
  logic        first_ff, overflow_ff, busy_ff;
  logic [7:0]  len_ff, cnt_ff;
  logic [2:0]  sel_ff;
  // AHB address phase capture
  logic        wr_ff, rd_ff;
  logic [7:0]  adr_ff;
  wire acc     = hsel && hready && htrans[1];
  wire wr_now  = wr_ff;
  wire [2:0] widx = adr_ff[4:2];

  // Config decode
  wire mode_var  = ctrl_ff[CTRL_MODE];
  wire address_length_select  = ctrl_ff[CTRL_ADDRESS_LENGTH_SELECT];
  wire start_sel = ctrl_ff[CTRL_START_SEL];
  wire stop_11   = ctrl_ff[CTRL_STOP_LO+1 -: 2] == STOP_FIRST_ONLY[1:0];
  wire [7:0] lower_limit = lim_ff[7:0];
  wire [7:0] upper_limit = lim_ff[15:8];
  wire [7:0] gain_strength_offset = lim_ff[23:16];
  wire [GW-1:0] saturation_gain_value = gain_ff[GW-1:0];

  // Event timeout use: first search only, or every search
  wire ev2_applies = stop_11 && (start_sel || first_ff);
  wire lim_applies = (search_ff != RESET_ZERO) && !(stop_11 && (start_sel || first_ff));
  wire searching   = state_ff == RRX_SEARCH;
  wire nosync      = searching && lim_applies && (timer_ff >= search_ff);
  wire ev2_end     = searching && ev2_applies && stop_event;

  // Address match against entries enabled (bit 8) for this sync word
  logic [ENTRIES-1:0] hit, enab;
  logic [2:0] hit_idx;
  logic       any_hit;
  always_comb
  begin
    hit_idx = '0;
    any_hit = 1'b0;
    for (int i = ENTRIES - 1; i >= 0; i--)
    begin
      enab[i] = entry_ff[i][8];
      hit[i]  = enab[i] && (!address_length_select || entry_ff[i][7:0] == rx_byte);
      if (hit[i])
      begin
        hit_idx = 3'(i);
        any_hit = 1'b1;
      end
    end
  end
  wire [15:0] good_sel = good_ff[sel_ff]; // Counter of the entry in use
  wire [7:0] hit_len = entry_ff[hit_idx][23:16];
  wire len_short = mode_var && byte_valid && (rx_byte < {7'h00, address_length_select});
  wire addr_drop = !any_hit;
  wire len_big   = mode_var && (len_ff > hit_len);
  wire is_empty  = len_ff == {7'h00, address_length_select};
  wire in_addr   = state_ff == RRX_ADDR && (byte_valid || !address_length_select);
  wire pkt_fin   = state_ff == RRX_BODY && pkt_end;
  wire would_drop = (!crc_ok && ctrl_ff[CTRL_FLUSH_CRC]) ||
                    (is_empty && ctrl_ff[CTRL_FLUSH_EMP]);

  // Task sequencing
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      RRX_IDLE:   if (rx_cmd) nxt_state = RRX_SEARCH;
      RRX_SEARCH: if (nosync || ev2_end || mod_underflow) nxt_state = RRX_DONE;
                  else if (sync_found) nxt_state = mode_var ? RRX_LEN : RRX_ADDR;
      RRX_LEN:    if (len_short) nxt_state = RRX_SEARCH;
                  else if (byte_valid) nxt_state = RRX_ADDR;
      RRX_ADDR:   if (in_addr) nxt_state = (addr_drop || len_big) ? RRX_SEARCH : RRX_BODY;
      RRX_BODY:   if (pkt_end) nxt_state = RRX_DONE;
      RRX_DONE:   nxt_state = RRX_IDLE;
      default:    nxt_state = RRX_IDLE;
    endcase
  end

  wire task_start = state_ff == RRX_IDLE && rx_cmd;
  wire rx_off     = state_ff == RRX_DONE;
  wire sync_hold  = !(searching || state_ff == RRX_IDLE);
  logic gain_low;

  rrxage_agc #(.GW(GW)) u_agc (
    .clock          (clock),
    .srst           (srst),
    .enable         (ctrl_ff[CTRL_GAIN_CONTROL_ENABLE]),
    .task_start     (task_start),
    .rx_off         (rx_off),
    .sync_hold      (!searching),     // Gain moves only while searching
    .strength_valid (strength_valid),
    .strength       (strength),
    .lower_limit    (lower_limit),
    .upper_limit    (upper_limit),
    .gain_in        (gain_ff[GW+15:16]),
    .sat_gain       (saturation_gain_value),
    .gain_out       (front_end_gain_setting),
    .gain_low       (gain_low)
  );

  // Task engine registers
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_ff    <= RRX_IDLE;
      timer_ff    <= '0;
      first_ff    <= 1'b0;
      overflow_ff <= 1'b0;
      len_ff      <= '0;
      sel_ff      <= '0;
      cause_ff    <= END_OK;
      last_str_ff <= '0;
      res_ff      <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      // Timer keeps running across dropped packets
      if (task_start)
        timer_ff <= '0;
      else if (searching || state_ff == RRX_LEN || state_ff == RRX_ADDR)
        timer_ff <= timer_ff + 32'h1;
      if (task_start)
        first_ff <= 1'b1;
      else if (pkt_fin)
        first_ff <= 1'b0; // Dropped packets keep first status
      if (sync_found && searching)
        overflow_ff <= 1'b0;
      else if (fifo_full && state_ff == RRX_BODY)
        overflow_ff <= 1'b1;
      if (state_ff == RRX_LEN && byte_valid)
        len_ff <= rx_byte;
      if (in_addr && !addr_drop)
      begin
        sel_ff <= hit_idx;
        if (!mode_var)
          len_ff <= hit_len;
      end
      if (nosync)
        cause_ff <= end_no_sync;
      else if (mod_underflow && searching)
        cause_ff <= end_modulator_underflow;
      else if (ev2_end)
        cause_ff <= END_RX_TIMEOUT;
      else if (pkt_fin)
        cause_ff <= END_OK;
      if (strength_valid && sync_hold)
        last_str_ff <= gain_low ? strength + gain_strength_offset : strength;
      if (pkt_fin && ctrl_ff[CTRL_STATUS_EN])
        res_ff <= {crc_ok, 7'h00};
    end
  end

  // Event outputs are pulses decoded from the engine state
  assign capture_pulse   = searching && sync_found;
  assign discard_rx_fifo = pkt_fin && (would_drop || overflow_ff || fifo_full);
  wire   ovf_err         = pkt_fin && (overflow_ff || fifo_full) && !would_drop;
  assign rx_overflow_irq = ovf_err;
  assign rx_good_irq     = pkt_fin && !ovf_err && crc_ok && !is_empty;
  assign rx_empty_irq    = pkt_fin && !ovf_err && crc_ok && is_empty;
  assign rx_bad_irq      = pkt_fin && !ovf_err && !crc_ok;
  assign task_done       = rx_off;
  assign status_result_byte = res_ff;
  assign channel_number  = gain_ff[14:8];
  // Tone settings; offset clamped to its ceiling
  assign tone_enable     = ctrl_ff[CTRL_TONE_EN];
  assign tone_length     = tone_ff[15:0];
  assign synth_reduction = !tone_enable ? 16'h0000 :
                           (tone_ff[31:16] > TONE_OFS_MAX) ? TONE_OFS_MAX : tone_ff[31:16];

  // Bus side: registered write, zero-wait read
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wr_ff  <= 1'b0;
      rd_ff  <= 1'b0;
      adr_ff <= '0;
    end
    else
    begin
      wr_ff  <= acc && hwrite;
      rd_ff  <= acc && !hwrite;
      adr_ff <= haddr[7:0];
    end
  end

  // Software registers and counters (counters have no write path, hardware increment only)
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ctrl_ff   <= RESET_ZERO;
      gain_ff   <= RESET_ZERO;
      lim_ff    <= RESET_ZERO;
      tone_ff   <= RESET_ZERO;
      search_ff <= RESET_ZERO;
      for (int i = 0; i < ENTRIES; i++)
      begin
        entry_ff[i] <= RESET_ZERO;
        good_ff[i]  <= '0;
        bad_ff[i]   <= '0;
      end
    end
    else
    begin
      if (wr_now && adr_ff == OFS_CTRL)   ctrl_ff   <= hwdata;
      if (wr_now && adr_ff == OFS_GAIN)   gain_ff   <= hwdata;
      if (wr_now && adr_ff == OFS_LIMITS) lim_ff    <= hwdata;
      if (wr_now && adr_ff == OFS_TONE)   tone_ff   <= hwdata;
      if (wr_now && adr_ff == OFS_SEARCH) search_ff <= hwdata;
      if (wr_now && adr_ff[7:5] == OFS_ENTRY0[7:5])
        entry_ff[widx] <= hwdata;
      if (pkt_fin && !ovf_err && crc_ok)
        good_ff[sel_ff] <= good_ff[sel_ff] + 16'h1;
      if (pkt_fin && !ovf_err && !crc_ok)
        bad_ff[sel_ff] <= bad_ff[sel_ff] + 16'h1;
    end
  end

  // Read mux
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (rd_ff)
    begin
      if (adr_ff == OFS_CTRL)     hrdata = ctrl_ff;
      if (adr_ff == OFS_GAIN)     hrdata = {gain_ff[31:GW], front_end_gain_setting};
      if (adr_ff == OFS_LIMITS)   hrdata = lim_ff;
      if (adr_ff == OFS_TONE)     hrdata = tone_ff;
      if (adr_ff == OFS_SEARCH)   hrdata = search_ff;
      if (adr_ff == OFS_STATUS)   hrdata = {13'h0000, state_ff, res_ff, cause_ff};
      if (adr_ff == OFS_STRENGTH) hrdata = {24'h00_0000, last_str_ff};
      if (adr_ff[7:5] == OFS_ENTRY0[7:5]) hrdata = entry_ff[widx];
      if (adr_ff[7:5] == OFS_COUNT0[7:5]) hrdata = {bad_ff[widx], good_ff[widx]};
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  sequence s_searching;
    searching && lim_applies && timer_ff >= search_ff;
  endsequence
  chk_nosync_end: assert property (@(posedge clock) disable iff (srst)
    s_searching ##1 1'b1 |-> (cause_ff == end_no_sync && state_ff == RRX_DONE))
    else $error("no-sync ending missing");
  chk_capture_sync: assert property (@(posedge clock) disable iff (srst)
    (capture_pulse && !nosync && !ev2_end && !mod_underflow) |=> state_ff != RRX_SEARCH)
    else $error("capture without leaving search");
  chk_short_drop: assert property (@(posedge clock) disable iff (srst)
    (state_ff == RRX_LEN && len_short) |=> state_ff == RRX_SEARCH)
    else $error("short length not dropped");
  chk_overflow_irq: assert property (@(posedge clock) disable iff (srst)
    rx_overflow_irq |-> !rx_good_irq && !rx_empty_irq && !rx_bad_irq && discard_rx_fifo)
    else $error("overflow with normal interrupt");
  chk_tone_cap: assert property (@(posedge clock) disable iff (srst)
    synth_reduction <= TONE_OFS_MAX)
    else $error("tone offset above ceiling");
  chk_good_count: assert property (@(posedge clock) disable iff (srst)
    (rx_good_irq || rx_empty_irq) |=> good_sel == $past(good_sel) + 16'h1)
    else $error("good counter not incremented");
  chk_crc_flush: assert property (@(posedge clock) disable iff (srst)
    (pkt_fin && !crc_ok && ctrl_ff[CTRL_FLUSH_CRC]) |-> discard_rx_fifo)
    else $error("crc failure not flushed");
  chk_empty_flush: assert property (@(posedge clock) disable iff (srst)
    (pkt_fin && is_empty && ctrl_ff[CTRL_FLUSH_EMP]) |-> discard_rx_fifo)
    else $error("empty packet not flushed");
endmodule
